/* hdl/iahc_map.vh */
// Register offsets, field positions, reset values and timing counts
`ifndef IAHC_MAP_VH
`define IAHC_MAP_VH
// Register byte offsets
`define IAHC_CTRL 8'h00
`define IAHC_EXTCFG 8'h04
`define IAHC_PSTAT 8'h08
`define IAHC_PASSOC 8'h0C
`define IAHC_PEN 8'h10
`define IAHC_TMRCFG 8'h14
`define IAHC_STATUS 8'h18
// CTRL fields
`define IAHC_IMASK_BIT 0
`define IAHC_IMASK_RST 1'b1
// EXTCFG fields
`define IAHC_POL_LO 0
`define IAHC_EDGE_LO 4
`define IAHC_NANDEN_LO 8
// TMRCFG fields
`define IAHC_TIMEBASE_INTERRUPT_ENABLE_BIT 0
`define IAHC_OVERFLOW_INTERRUPT_ENABLE_BIT 1
`define IAHC_CKS_LO 2
`define IAHC_WDGH_BIT 4
// Autoreload counter clock codes
`define IAHC_CKS_OFF 2'h0
`define IAHC_CKS_TB 2'h1
`define IAHC_CKS_CPU 2'h2
`define IAHC_CKS_RSV 2'h3
// Vector identifiers, lowest wins
`define IAHC_VEC_TRAP 4'h0
`define IAHC_VEC_TB 4'h4
`define IAHC_VEC_AR 4'h5
// Start-up delay after reset wake from active halt
`define IAHC_STARTUP_CYC 9'h100
`endif

/* hdl/iahc_ctrl.v */
// Interrupt entry/exit sequencer and active-halt controller with APB registers
//
// Implementation choices: the register addresses and register access over APB.
`timescale 1ns/100ps
`default_nettype none
`include "iahc_map.vh"

module iahc_ctrl (
   // Clock and reset
   input wire SYS_CLK,
   input wire RSTN,
   // APB slave
   input wire PSEL,
   input wire PENABLE,
   input wire PWRITE,
   input wire [7:0] PADDR,
   input wire [31:0] PWDATA,
   output reg [31:0] PRDATA,
   output reg PREADY,
   output reg PSLVERR,
   // Core events
   input wire INSTR_END,
   input wire TRAP_EXEC,
   input wire RETURN_FROM_INTERRUPT_EXEC,
   input wire HALT_EXEC,
   input wire WAIT_EXEC,
   input wire WAKE_RESET,
   input wire WDG_ACTIVE,
   // Request sources
   input wire [1:0] EXT_PIN,
   input wire [3:0] NAND_PIN,
   input wire TB_OVF,
   input wire AR_OVF,
   input wire [3:0] PERIPH_EVT,
   // Core control
   output reg I_FLAG,
   output reg SUSPEND,
   output reg CTX_PUSH,
   output reg CTX_POP,
   output reg [1:0] CTX_SEL,
   output reg VEC_LOAD,
   output reg [3:0] VEC_ID,
   output reg FETCH,
   output reg RESET_FETCH,
   output reg WDG_RESET,
   // Clock gating
   output reg OSC_EN,
   output reg CORE_CLK_EN,
   output reg PERIPH_CLK_EN,
   output reg TB_CLK_EN,
   output reg AR_CLK_EN,
   output reg [1:0] AR_CLK_SRC
);

   localparam S_RUN = 8'h01;
   localparam S_PUSH = 8'h02;
   localparam S_VEC = 8'h04;
   localparam S_POP = 8'h08;
   localparam S_WAIT = 8'h10;
   localparam S_HALT = 8'h20;
   localparam S_AHALT = 8'h40;
   localparam S_START = 8'h80;

   // Lowest set bit wins
   function [3:0] prio;
      input [9:0] v;
      integer i;
      begin
         prio = 4'h0;
         for (i = 9; i >= 0; i = i - 1) begin
            if (v[i]) begin
               prio = i[3:0];
            end
         end
      end
   endfunction

   reg [7:0] state;
   reg [1:0] cnt;
   reg [3:0] sel;
   reg [8:0] su_cnt;
   reg trap_pend;
   reg [2:0] ext_pol;
   reg [2:0] ext_edge;
   reg [3:0] nand_en;
   reg [2:0] ext_lat;
   reg [2:0] ext_prev;
   reg [3:0] pflag;
   reg [3:0] pen;
   reg [3:0] parm;
   reg [7:0] passoc;
   reg tb_flag;
   reg ar_flag;
   reg timebase_interrupt_enable;
   reg overflow_interrupt_enable;
   reg [1:0] cks;
   reg wdg_halt;
   reg [31:0] rdata;
   reg hit;

   // Combined pin group, idle when no pin enabled
   wire nand_out = ~&(NAND_PIN | ~nand_en);
   wire [2:0] ext_raw = {nand_out, EXT_PIN} ^ ext_pol;
   wire [2:0] ext_rise = ext_raw & ~ext_prev;
   wire [2:0] ext_req = (ext_edge & ext_lat) | (~ext_edge & ext_raw);
   wire tb_req = tb_flag & timebase_interrupt_enable;
   wire ar_req = ar_flag & overflow_interrupt_enable;
   wire [3:0] p_req = pflag & pen;
   wire [8:0] mreq = {p_req, ar_req, tb_req, ext_req};
   wire [9:0] elig = {mreq & {9{~I_FLAG}}, trap_pend};
   wire take = (|elig) & INSTR_END;
   wire ah_en = timebase_interrupt_enable | (overflow_interrupt_enable & (cks == `IAHC_CKS_TB));
   wire [9:0] ent_clr = {9'h000, state == S_VEC} << sel;

   // Answer built on first access edge, action on the completing edge
   wire acc = PSEL & PENABLE & ~PREADY;
   wire done = PSEL & PENABLE & PREADY;
   wire wr_en = done & PWRITE;
   wire rd_en = done & ~PWRITE;

   // Register read mux and address decode
   always @* begin
      rdata = 32'h00000000;
      hit = 1'b1;
      case (PADDR)
         `IAHC_CTRL: rdata = {31'h00000000, I_FLAG};
         `IAHC_EXTCFG: rdata = {20'h00000, nand_en, 1'b0, ext_edge, 1'b0, ext_pol};
         `IAHC_PSTAT: rdata = {28'h0000000, pflag};
         `IAHC_PASSOC: rdata = {24'h000000, passoc};
         `IAHC_PEN: rdata = {28'h0000000, pen};
         `IAHC_TMRCFG: rdata = {27'h0000000, wdg_halt, cks, overflow_interrupt_enable, timebase_interrupt_enable};
         `IAHC_STATUS: rdata = {10'h000, trap_pend, ar_flag, tb_flag, ext_req,
                                4'h0, sel, state};
         default: hit = 1'b0;
      endcase
   end

   // APB answer, one wait state
   always @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         PREADY <= 1'b0;
         PSLVERR <= 1'b0;
         PRDATA <= 32'h00000000;
      end else begin
         PREADY <= acc;
         PSLVERR <= acc & ~hit;
         PRDATA <= (acc & ~PWRITE & hit) ? rdata : 32'h00000000;
      end
   end

   // Configuration registers
   always @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         ext_pol <= 3'h0;
         ext_edge <= 3'h0;
         nand_en <= 4'h0;
         pen <= 4'h0;
         passoc <= 8'h00;
         timebase_interrupt_enable <= 1'b0;
         overflow_interrupt_enable <= 1'b0;
         cks <= `IAHC_CKS_OFF;
         wdg_halt <= 1'b0;
      end else if (wr_en) begin
         case (PADDR)
            `IAHC_EXTCFG: begin
               ext_pol <= PWDATA[`IAHC_POL_LO +: 3];
               ext_edge <= PWDATA[`IAHC_EDGE_LO +: 3];
               nand_en <= PWDATA[`IAHC_NANDEN_LO +: 4];
            end
            `IAHC_PASSOC: passoc <= PWDATA[7:0];
            `IAHC_PEN: pen <= PWDATA[3:0];
            `IAHC_TMRCFG: begin
               timebase_interrupt_enable <= PWDATA[`IAHC_TIMEBASE_INTERRUPT_ENABLE_BIT];
               overflow_interrupt_enable <= PWDATA[`IAHC_OVERFLOW_INTERRUPT_ENABLE_BIT];
               cks <= PWDATA[`IAHC_CKS_LO +: 2];
               wdg_halt <= PWDATA[`IAHC_WDGH_BIT];
            end
            default: begin
            end
         endcase
      end
   end

   // Request latches; a new event wins over a same-cycle clear
   always @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         ext_prev <= 3'h0;
         ext_lat <= 3'h0;
         trap_pend <= 1'b0;
         tb_flag <= 1'b0;
         ar_flag <= 1'b0;
         pflag <= 4'h0;
         parm <= 4'h0;
      end else begin
         ext_prev <= ext_raw;
         ext_lat <= (ext_lat & ~ent_clr[3:1]) | (ext_rise & ext_edge);
         trap_pend <= (trap_pend & ~ent_clr[0]) | TRAP_EXEC;
         tb_flag <= (tb_flag & ~ent_clr[4]) | TB_OVF;
         ar_flag <= (ar_flag & ~ent_clr[5]) | AR_OVF;
         if (wr_en && PADDR == `IAHC_PSTAT) begin
            pflag <= (pflag & PWDATA[3:0]) | PERIPH_EVT;
            parm <= 4'h0;
         end else if (rd_en && PADDR == `IAHC_PSTAT) begin
            pflag <= pflag | PERIPH_EVT;
            parm <= pflag;
         end else if (done && PADDR == `IAHC_PASSOC) begin
            pflag <= (pflag & ~parm) | PERIPH_EVT;
            parm <= 4'h0;
         end else begin
            pflag <= pflag | PERIPH_EVT;
         end
      end
   end

   // Entry, return and low-power sequencer
   always @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         state <= S_RUN;
         cnt <= 2'h0;
         sel <= 4'h0;
         su_cnt <= 9'h000;
         I_FLAG <= `IAHC_IMASK_RST;
         SUSPEND <= 1'b0;
         CTX_PUSH <= 1'b0;
         CTX_POP <= 1'b0;
         CTX_SEL <= 2'h0;
         VEC_LOAD <= 1'b0;
         VEC_ID <= 4'h0;
         FETCH <= 1'b0;
         RESET_FETCH <= 1'b0;
         WDG_RESET <= 1'b0;
      end else begin
         SUSPEND <= 1'b0;
         CTX_PUSH <= 1'b0;
         CTX_POP <= 1'b0;
         VEC_LOAD <= 1'b0;
         RESET_FETCH <= 1'b0;
         WDG_RESET <= 1'b0;
         FETCH <= VEC_LOAD;
         if (wr_en && PADDR == `IAHC_CTRL) begin
            I_FLAG <= PWDATA[`IAHC_IMASK_BIT];
         end
         case (state)
            S_RUN: begin
               if (take) begin
                  SUSPEND <= 1'b1;
                  sel <= prio(elig);
                  cnt <= 2'h0;
                  state <= S_PUSH;
               end else if (RETURN_FROM_INTERRUPT_EXEC) begin
                  cnt <= 2'h0;
                  state <= S_POP;
               end else if (HALT_EXEC) begin
                  if (WDG_ACTIVE && wdg_halt) begin
                     WDG_RESET <= 1'b1;
                  end else if (ah_en) begin
                     I_FLAG <= 1'b0;
                     state <= S_AHALT;
                  end else begin
                     state <= S_HALT;
                  end
               end else if (WAIT_EXEC) begin
                  state <= S_WAIT;
               end
            end
            S_PUSH: begin
               // Order: PC, X, A, CC
               CTX_PUSH <= 1'b1;
               CTX_SEL <= cnt;
               cnt <= cnt + 2'h1;
               if (cnt == 2'h3) begin
                  state <= S_VEC;
               end
            end
            S_VEC: begin
               I_FLAG <= 1'b1;
               VEC_LOAD <= 1'b1;
               VEC_ID <= sel;
               state <= S_RUN;
            end
            S_POP: begin
               // Reverse order: CC, A, X, PC
               CTX_POP <= 1'b1;
               CTX_SEL <= 2'h3 - cnt;
               cnt <= cnt + 2'h1;
               if (cnt == 2'h3) begin
                  I_FLAG <= 1'b0;
                  state <= S_RUN;
               end
            end
            S_WAIT: begin
               if ((|mreq) || trap_pend) begin
                  state <= S_RUN;
               end
            end
            S_HALT: begin
               if (|ext_req) begin
                  state <= S_RUN;
               end
            end
            S_AHALT: begin
               if (WAKE_RESET) begin
                  su_cnt <= 9'h000;
                  state <= S_START;
               end else if (tb_req || ar_req) begin
                  // Immediate wake straight into entry
                  SUSPEND <= 1'b1;
                  sel <= tb_req ? `IAHC_VEC_TB : `IAHC_VEC_AR;
                  cnt <= 2'h0;
                  state <= S_PUSH;
               end
            end
            S_START: begin
               su_cnt <= su_cnt + 9'h001;
               if (su_cnt == `IAHC_STARTUP_CYC - 9'h001) begin
                  RESET_FETCH <= 1'b1;
                  I_FLAG <= `IAHC_IMASK_RST;
                  state <= S_RUN;
               end
            end
            default: state <= S_RUN;
         endcase
      end
   end

   // Clock gating follows the current state
   always @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         OSC_EN <= 1'b1;
         CORE_CLK_EN <= 1'b1;
         PERIPH_CLK_EN <= 1'b1;
         TB_CLK_EN <= 1'b1;
         AR_CLK_EN <= 1'b0;
         AR_CLK_SRC <= `IAHC_CKS_OFF;
      end else begin
         OSC_EN <= (state != S_HALT);
         CORE_CLK_EN <= ((state & (S_RUN | S_PUSH | S_VEC | S_POP)) != 8'h00);
         PERIPH_CLK_EN <= ((state & (S_HALT | S_AHALT | S_START)) == 8'h00);
         if (state == S_AHALT) begin
            TB_CLK_EN <= ah_en;
            AR_CLK_EN <= overflow_interrupt_enable & (cks == `IAHC_CKS_TB);
         end else begin
            TB_CLK_EN <= (state != S_HALT);
            AR_CLK_EN <= (state != S_HALT) & (cks != `IAHC_CKS_OFF) & (cks != `IAHC_CKS_RSV);
         end
         AR_CLK_SRC <= (cks == `IAHC_CKS_RSV) ? `IAHC_CKS_OFF : cks;
      end
   end

endmodule
`default_nettype wire

/* sim/iahc_core_model.sv */
// Core stack model: issues instruction ends, checks push and pop order
`timescale 1ns/100ps
`default_nettype none
module iahc_core_model (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Stack traffic
   input wire logic push,
   input wire logic pop,
   input wire logic [1:0] sel,
   // Core side
   output logic instr_end,
   output logic [7:0] bad
);
   logic [1:0] ph;
   logic [1:0] stk[$];
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ph <= 2'h0;
         instr_end <= 1'b0;
         bad <= 8'h00;
         stk.delete();
      end else begin
         ph <= ph + 2'h1;
         instr_end <= (ph == 2'h2);
         if (push === 1'b1) begin
            if (sel !== 2'(stk.size())) bad <= bad + 8'h01;
            stk.push_back(sel);
         end
         if (pop === 1'b1) begin
            if (stk.size() == 0 || stk[$] !== sel) bad <= bad + 8'h01;
            else void'(stk.pop_back());
         end
      end
   end
endmodule
`default_nettype wire

/* sim/iahc_ctrl_assertions.sv */
// Concurrent checks on the sequencer ports
`timescale 1ns/100ps
`default_nettype none
module iahc_ctrl_assertions (
   // Clock and reset
   input wire SYS_CLK, RSTN,
   // Observed
   input wire PREADY, PSLVERR, I_FLAG, SUSPEND, CTX_PUSH, CTX_POP,
   input wire [1:0] CTX_SEL,
   input wire VEC_LOAD,
   input wire [3:0] VEC_ID,
   input wire FETCH, HALT_EXEC, WDG_ACTIVE, WDG_RESET,
   input wire [1:0] AR_CLK_SRC
);
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RSTN);
   a_mask_after_reset: assert property ($rose(RSTN) |-> I_FLAG)
      else $error("mask flag clear after reset");
   a_push_vec_order: assert property (SUSPEND |=> (CTX_PUSH && CTX_SEL == 2'h0)
      ##1 (CTX_PUSH && CTX_SEL == 2'h1) ##1 (CTX_PUSH && CTX_SEL == 2'h2)
      ##1 (CTX_PUSH && CTX_SEL == 2'h3) ##1 VEC_LOAD ##1 FETCH)
      else $error("entry sequence broken");
   a_vec_sets_mask: assert property (VEC_LOAD |-> I_FLAG && VEC_ID <= 4'h9)
      else $error("vector load without mask");
   a_pop_clears_mask: assert property ($rose(CTX_POP) |-> CTX_SEL == 2'h3
      ##1 CTX_SEL == 2'h2 ##1 CTX_SEL == 2'h1 ##1 CTX_SEL == 2'h0 ##1 !I_FLAG)
      else $error("return sequence broken");
   a_wdg_cause: assert property (WDG_RESET |-> $past(HALT_EXEC) && $past(WDG_ACTIVE))
      else $error("watchdog reset without halt");
   a_src_not_rsv: assert property (AR_CLK_SRC != 2'h3)
      else $error("reserved counter clock");
   a_err_with_ready: assert property (PSLVERR |-> PREADY)
      else $error("error without ready");
   a_ready_pulse: assert property (PREADY |=> !PREADY)
      else $error("ready longer than a cycle");
endmodule
bind iahc_ctrl iahc_ctrl_assertions u_chk (.SYS_CLK, .RSTN, .PREADY, .PSLVERR, .I_FLAG,
   .SUSPEND, .CTX_PUSH, .CTX_POP, .CTX_SEL, .VEC_LOAD, .VEC_ID, .FETCH, .HALT_EXEC,
   .WDG_ACTIVE, .WDG_RESET, .AR_CLK_SRC);
`default_nettype wire

/* sim/tb_iahc_ctrl.sv */
// Self-checking bench for the interrupt and active-halt controller
`timescale 1ns/100ps
`default_nettype none
`include "iahc_map.vh"
module tb_iahc_ctrl;
   logic SYS_CLK = 0, RSTN = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, TRAP_EXEC = 0;
   logic RETURN_FROM_INTERRUPT_EXEC = 0, HALT_EXEC = 0, WAKE_RESET = 0, WDG_ACTIVE = 0, TB_OVF = 0;
   logic WAIT_EXEC = 0, AR_OVF = 0;
   logic [1:0] EXT_PIN = 2'h0;
   logic [3:0] NAND_PIN = 4'hF;
   logic [7:0] PADDR = 8'h00;
   logic [31:0] PWDATA = 32'h0, rd;
   logic [3:0] PERIPH_EVT = 4'h0;
   logic er;
   wire [31:0] PRDATA;
   wire [3:0] VEC_ID;
   wire [1:0] CTX_SEL, AR_CLK_SRC;
   wire [7:0] bad;
   wire PREADY, PSLVERR, INSTR_END, I_FLAG, SUSPEND, CTX_PUSH, CTX_POP, VEC_LOAD, FETCH;
   wire RESET_FETCH, WDG_RESET, OSC_EN, CORE_CLK_EN, PERIPH_CLK_EN, TB_CLK_EN, AR_CLK_EN;
   int errors = 0, check_count = 0, cyc = 0, vc = 0, wc = 0, i, n, k, ps;
   int seed = 32'hd8017dfb;
   logic [3:0] lv;
   logic [31:0] d;
   iahc_ctrl dut (.SYS_CLK, .RSTN, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
      .PREADY, .PSLVERR, .INSTR_END, .TRAP_EXEC, .RETURN_FROM_INTERRUPT_EXEC, .HALT_EXEC, .WAIT_EXEC,
      .WAKE_RESET, .WDG_ACTIVE, .EXT_PIN, .NAND_PIN, .TB_OVF, .AR_OVF,
      .PERIPH_EVT, .I_FLAG, .SUSPEND, .CTX_PUSH, .CTX_POP, .CTX_SEL, .VEC_LOAD, .VEC_ID,
      .FETCH, .RESET_FETCH, .WDG_RESET, .OSC_EN, .CORE_CLK_EN, .PERIPH_CLK_EN, .TB_CLK_EN,
      .AR_CLK_EN, .AR_CLK_SRC);
   iahc_core_model core (.clk(SYS_CLK), .rstn(RSTN), .push(CTX_PUSH), .pop(CTX_POP),
      .sel(CTX_SEL), .instr_end(INSTR_END), .bad(bad));
   initial begin
      forever #20 SYS_CLK = ~SYS_CLK;
   end
   always @(posedge SYS_CLK) begin
      cyc++;
      if (VEC_LOAD === 1'b1) begin
         vc <= vc + 1;
         lv <= VEC_ID;
      end
      if (WDG_RESET === 1'b1) wc <= wc + 1;
      if (cyc == 6000) begin
         errors++;
         give_verdict();
      end
   end
   task give_verdict;
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      check_count++;
      if (e !== s) begin
         errors++;
         $display("MISMATCH %s exp %h got %h", nm, e, s);
      end
   endtask
   task apb(input logic [7:0] a, input logic w, input logic [31:0] dat);
      @(posedge SYS_CLK);
      PSEL <= 1;
      PADDR <= a;
      PWRITE <= w;
      PWDATA <= dat;
      @(posedge SYS_CLK);
      PENABLE <= 1;
      do @(posedge SYS_CLK); while (PREADY !== 1'b1);
      rd = PRDATA;
      er = PSLVERR;
      PSEL <= 0;
      PENABLE <= 0;
   endtask
   // Pulse one core or source event for a cycle
   task pls(input int s, input logic [3:0] pe);
      @(posedge SYS_CLK);
      case (s)
         0: TRAP_EXEC <= 1;
         1: RETURN_FROM_INTERRUPT_EXEC <= 1;
         2: HALT_EXEC <= 1;
         3: WAKE_RESET <= 1;
         4: TB_OVF <= 1;
         6: WAIT_EXEC <= 1;
         7: AR_OVF <= 1;
         default: PERIPH_EVT <= pe;
      endcase
      @(posedge SYS_CLK);
      {TRAP_EXEC, RETURN_FROM_INTERRUPT_EXEC, HALT_EXEC, WAKE_RESET, TB_OVF, WAIT_EXEC, AR_OVF, PERIPH_EVT} <= 11'h000;
   endtask
   task wait_vec(input logic [3:0] ev);
      n = vc;
      for (i = 0; i < 60 && vc == n; i++) @(posedge SYS_CLK);
      chk("vector count", n + 1, vc);
      chk("vector id", ev, lv);
   endtask
   task ret;
      repeat (3) @(posedge SYS_CLK);
      pls(1, 4'h0);
      for (i = 0; i < 20 && I_FLAG !== 1'b0; i++) @(posedge SYS_CLK);
   endtask
   initial begin
      repeat (3) @(posedge SYS_CLK);
      RSTN <= 1;
      @(posedge SYS_CLK);
      chk("mask", 1, I_FLAG);
      apb(`IAHC_CTRL, 0, 0);
      chk("ctrl", 1, rd);
      apb(8'h40, 0, 0);
      chk("unmapped error", 1, er);
      chk("unmapped data", 0, rd);
      d = $random(seed);
      apb(`IAHC_PASSOC, 1, d);
      apb(`IAHC_PASSOC, 0, 0);
      chk("scratch", d[7:0], rd);
      pls(0, 4'h0);
      wait_vec(`IAHC_VEC_TRAP);
      ret();
      chk("mask after return", 0, I_FLAG);
      k = {$random(seed)} % 4;
      ps = 1 << k;
      n = vc;
      pls(5, ps[3:0]);
      apb(`IAHC_PSTAT, 0, 0);
      chk("pending flag", ps, rd);
      apb(`IAHC_PASSOC, 0, 0);
      apb(`IAHC_PSTAT, 0, 0);
      chk("cleared by sequence", 0, rd);
      pls(5, ps[3:0]);
      apb(`IAHC_PSTAT, 1, 0);
      apb(`IAHC_PEN, 1, 32'hF);
      repeat (20) @(posedge SYS_CLK);
      chk("discarded request", n, vc);
      pls(5, 4'hA);
      wait_vec(4'h7);
      apb(`IAHC_PSTAT, 1, 32'hD);
      ret();
      wait_vec(4'h9);
      apb(`IAHC_PSTAT, 1, 32'h0);
      ret();
      pls(6, 4'h0);
      repeat (3) @(posedge SYS_CLK);
      chk("wait core clock", 0, CORE_CLK_EN);
      pls(5, 4'h1);
      wait_vec(4'h6);
      apb(`IAHC_PSTAT, 1, 32'h0);
      ret();
      apb(`IAHC_CTRL, 1, 1);
      apb(`IAHC_EXTCFG, 1, 32'h10);
      @(posedge SYS_CLK);
      EXT_PIN <= 2'h1;
      @(posedge SYS_CLK);
      EXT_PIN <= 2'h0;
      n = vc;
      repeat (20) @(posedge SYS_CLK);
      chk("masked external", n, vc);
      apb(`IAHC_CTRL, 1, 0);
      wait_vec(4'h1);
      ret();
      n = vc;
      repeat (20) @(posedge SYS_CLK);
      chk("edge latch cleared", n, vc);
      apb(`IAHC_EXTCFG, 1, 32'h2);
      wait_vec(4'h2);
      EXT_PIN <= 2'h2;
      ret();
      apb(`IAHC_EXTCFG, 1, 32'h342);
      NAND_PIN <= 4'hE;
      wait_vec(4'h3);
      ret();
      NAND_PIN <= 4'hC;
      n = vc;
      repeat (20) @(posedge SYS_CLK);
      chk("nand group masked", n, vc);
      NAND_PIN <= 4'hF;
      pls(2, 4'h0);
      repeat (3) @(posedge SYS_CLK);
      chk("halt oscillator", 0, OSC_EN);
      NAND_PIN <= 4'hE;
      wait_vec(4'h3);
      NAND_PIN <= 4'hF;
      ret();
      apb(`IAHC_PEN, 1, 0);
      apb(`IAHC_TMRCFG, 1, 32'h1);
      apb(`IAHC_CTRL, 1, 1);
      WDG_ACTIVE <= 1;
      pls(2, 4'h0);
      repeat (3) @(posedge SYS_CLK);
      chk("halt mask", 0, I_FLAG);
      chk("halt clocks", 4'b1010, {OSC_EN, CORE_CLK_EN, TB_CLK_EN, PERIPH_CLK_EN});
      chk("no watchdog reset", 0, wc);
      pls(4, 4'h0);
      wait_vec(`IAHC_VEC_TB);
      chk("core clock back", 1, CORE_CLK_EN);
      ret();
      apb(`IAHC_TMRCFG, 1, 32'h6);
      pls(2, 4'h0);
      repeat (3) @(posedge SYS_CLK);
      chk("counter clock", 3'b101, {AR_CLK_EN, AR_CLK_SRC});
      pls(7, 4'h0);
      wait_vec(`IAHC_VEC_AR);
      ret();
      pls(2, 4'h0);
      repeat (3) @(posedge SYS_CLK);
      pls(3, 4'h0);
      n = 0;
      while (RESET_FETCH !== 1'b1 && n < 400) begin
         @(posedge SYS_CLK);
         n++;
      end
      chk("startup delay", 1, n >= 256 && n <= 259);
      chk("mask after wake", 1, I_FLAG);
      apb(`IAHC_TMRCFG, 1, 32'h8);
      repeat (2) @(posedge SYS_CLK);
      chk("cpu counter clock", 3'b110, {AR_CLK_EN, AR_CLK_SRC});
      apb(`IAHC_TMRCFG, 1, 32'hC);
      repeat (2) @(posedge SYS_CLK);
      chk("reserved counter clock", 3'b000, {AR_CLK_EN, AR_CLK_SRC});
      apb(`IAHC_TMRCFG, 1, 32'h10);
      pls(2, 4'h0);
      repeat (3) @(posedge SYS_CLK);
      chk("watchdog reset", 1, wc);
      chk("stack model", 0, bad);
      RSTN <= 0;
      repeat (2) @(posedge SYS_CLK);
      RSTN <= 1;
      @(posedge SYS_CLK);
      chk("mask after second reset", 1, I_FLAG);
      chk("counter clock after reset", 3'b000, {AR_CLK_EN, AR_CLK_SRC});
      give_verdict();
   end
endmodule
`default_nettype wire
